// ===== include/ictm_pkg.sv
// Constants, opcodes and carriers for the instruction cycle timing model.
// Assumes one 40 MHz system clock and synchronous request inputs.
package ictm_pkg;
    // =========================================================
    // Opcodes
    typedef enum logic [5:0] {
        OP_FIELD_TEST, OP_FIELD_INVERT, OP_FIELD_CLEAR, OP_FIELD_SET_ONES,
        OP_FIELD_EXTRACT_SIGNED, OP_FIELD_EXTRACT_UNSIGNED, OP_FIELD_INSERT,
        OP_FIELD_FIND_FIRST_ONE,
        OP_BRANCH_TAKEN, OP_BRANCH_NT_B, OP_BRANCH_NT_W, OP_BRANCH_NT_L,
        OP_LOOP_NOT_EXPIRED, OP_LOOP_EXPIRED, OP_LOOP_COND_TRUE,
        OP_SR_LOGIC, OP_SUBR_BRANCH,
        OP_MODULE_CALL_T0, OP_MODULE_CALL_T1_A, OP_MODULE_CALL_T1_B, OP_MODULE_CALL_T1_COPY,
        OP_CAS_OK, OP_CAS_FAIL, OP_DUAL_CAS_OK, OP_DUAL_CAS_FAIL,
        OP_BOUND_CHECK, OP_RANGE_CHECK, OP_INDIRECT_JUMP, OP_SUBROUTINE_JUMP,
        OP_LOAD_EFFECTIVE_ADDRESS, OP_LINK_W, OP_LINK_L, OP_NOP,
        OP_PUSH_EFFECTIVE_ADDRESS, OP_RET_DEALLOC, OP_MODULE_RETURN_T0,
        OP_MODULE_RETURN_T1, OP_RET_RESTORE, OP_RET_SUB, OP_UNLINK
    } ictm_op_t;

    // Which supplementary time the caller must add
    typedef enum logic [2:0] {
        ADD_NONE, ADD_CALC_IMM, ADD_FETCH_IMM, ADD_FETCH_EA, ADD_CALC_EA, ADD_JUMP_EA
    } ictm_add_t;

    typedef enum logic [1:0] {COL_BEST, COL_CACHE, COL_WORST} ictm_col_t;

    typedef struct packed {
        ictm_op_t   op;
        logic       mem_operand;   // Field op on memory
        logic       field_5byte;   // Field spans five bytes
        logic       prefetched;
        logic       cache_hit;
        logic [7:0] xfer_n;        // Stack copy transfer count
    } ictm_req_t;

    typedef struct packed {
        logic [10:0] total;
        logic [8:0]  reads;
        logic [3:0]  prefetches;
        logic [8:0]  writes;
        ictm_add_t   add_time;
        ictm_col_t   column;
    } ictm_rsp_t;

    // Entry: total, reads, prefetches, writes
    typedef struct packed {
        logic [7:0] t;
        logic [3:0] r;
        logic [3:0] p;
        logic [3:0] w;
    } ictm_ent_t;

    localparam logic [7:0] COPY_STEP     = 8'h06;
    localparam logic [8:0] COPY_RD_BASE  = 9'h007;
    localparam logic [8:0] COPY_WR_BASE  = 9'h008;
    localparam logic [3:0] FIELD_OPS     = 4'h8;
endpackage : ictm_pkg

// ===== core/ictm_core.sv
// Instruction cycle timing model: looks up clocks and bus cycle triple.
// Assumes requests are synchronous to clk_sys_i; one answer per request.
`timescale 1ns/1ps
`default_nettype none
module ictm_core
    import ictm_pkg::*;
(
    input  wire logic      clk_sys_i,  // 40 MHz clock
    input  wire logic      nrst_i,     // Async reset, active low
    input  wire logic      req_vld_i,  // Request strobe
    input  wire ictm_req_t req_i,      // Request fields
    output var  logic      rsp_vld_o,  // Answer valid, one cycle
    output var  ictm_rsp_t rsp_o       // Registered answer
);
    // =========================================================
    // State
    typedef struct packed {
        logic      vld;
        ictm_rsp_t rsp;
    } ictm_state_t;

    ictm_state_t st;
    ictm_state_t next_st;

    function automatic ictm_ent_t ent(input int t, input int r, input int p, input int w);
        ictm_ent_t e;
        e.t = 8'(t);
        e.r = 4'(r);
        e.p = 4'(p);
        e.w = 4'(w);
        return e;
    endfunction

    // =========================================================
    // Lookup of the three columns
    ictm_ent_t b;
    ictm_ent_t c;
    ictm_ent_t wc;
    ictm_add_t add;
    logic      copy;

    always_comb begin
        b    = ent(0, 0, 0, 0);
        c    = ent(0, 0, 0, 0);
        wc   = ent(0, 0, 0, 0);
        add  = ADD_NONE;
        copy = 1'b0;
        case (req_i.op)
            OP_FIELD_TEST: begin
                if (!req_i.mem_operand) begin
                    b = ent(3, 0, 0, 0); c = ent(6, 0, 0, 0); wc = ent(7, 0, 1, 0);
                end else if (req_i.field_5byte) begin
                    b = ent(15, 2, 0, 0); c = ent(15, 2, 0, 0); wc = ent(16, 2, 1, 0);
                end else begin
                    b = ent(11, 1, 0, 0); c = ent(11, 1, 0, 0); wc = ent(12, 1, 1, 0);
                end
            end
            OP_FIELD_INVERT, OP_FIELD_CLEAR, OP_FIELD_SET_ONES: begin
                if (!req_i.mem_operand) begin
                    b = ent(9, 0, 0, 0); c = ent(12, 0, 0, 0); wc = ent(12, 0, 1, 0);
                end else if (req_i.field_5byte) begin
                    b = ent(24, 2, 0, 2); c = ent(24, 2, 0, 2); wc = ent(24, 2, 1, 2);
                end else begin
                    b = ent(16, 1, 0, 1); c = ent(16, 1, 0, 1); wc = ent(16, 1, 1, 1);
                end
            end
            OP_FIELD_EXTRACT_SIGNED, OP_FIELD_EXTRACT_UNSIGNED: begin
                if (!req_i.mem_operand) begin
                    b = ent(5, 0, 0, 0); c = ent(8, 0, 0, 0); wc = ent(8, 0, 1, 0);
                end else if (req_i.field_5byte) begin
                    b = ent(18, 2, 0, 0); c = ent(18, 2, 0, 0); wc = ent(18, 2, 1, 0);
                end else begin
                    b = ent(13, 1, 0, 0); c = ent(13, 1, 0, 0); wc = ent(13, 1, 1, 0);
                end
            end
            OP_FIELD_INSERT: begin
                if (!req_i.mem_operand) begin
                    b = ent(7, 0, 0, 0); c = ent(10, 0, 0, 0); wc = ent(10, 0, 1, 0);
                end else if (req_i.field_5byte) begin
                    b = ent(20, 2, 0, 2); c = ent(20, 2, 0, 2); wc = ent(21, 2, 1, 2);
                end else begin
                    b = ent(14, 1, 0, 1); c = ent(14, 1, 0, 1); wc = ent(15, 1, 1, 1);
                end
            end
            OP_FIELD_FIND_FIRST_ONE: begin
                if (!req_i.mem_operand) begin
                    b = ent(15, 0, 0, 0); c = ent(18, 0, 0, 0); wc = ent(18, 0, 1, 0);
                end else if (req_i.field_5byte) begin
                    b = ent(32, 2, 0, 0); c = ent(32, 2, 0, 0); wc = ent(32, 2, 1, 0);
                end else begin
                    b = ent(24, 1, 0, 0); c = ent(24, 1, 0, 0); wc = ent(24, 1, 1, 0);
                end
            end
            // Branch entries are complete; add stays none
            OP_BRANCH_TAKEN, OP_BRANCH_NT_L: begin
                b = ent(3, 0, 0, 0); c = ent(6, 0, 0, 0); wc = ent(9, 0, 2, 0);
                if (req_i.op == OP_BRANCH_NT_L) begin
                    c = ent(6, 0, 0, 0);
                end
            end
            OP_BRANCH_NT_B: begin
                b = ent(1, 0, 0, 0); c = ent(4, 0, 0, 0); wc = ent(5, 0, 1, 0);
            end
            OP_BRANCH_NT_W, OP_LOOP_COND_TRUE: begin
                b = ent(3, 0, 0, 0); c = ent(6, 0, 0, 0); wc = ent(7, 0, 1, 0);
            end
            OP_LOOP_NOT_EXPIRED: begin
                b = ent(3, 0, 0, 0); c = ent(6, 0, 0, 0); wc = ent(9, 0, 2, 0);
            end
            OP_LOOP_EXPIRED: begin
                b = ent(7, 0, 0, 0); c = ent(10, 0, 0, 0); wc = ent(10, 0, 3, 0);
            end
            OP_SR_LOGIC: begin
                b = ent(9, 0, 0, 0); c = ent(12, 0, 0, 0); wc = ent(15, 0, 2, 0);
            end
            OP_SUBR_BRANCH: begin
                b = ent(5, 0, 0, 1); c = ent(7, 0, 0, 1); wc = ent(13, 0, 2, 1);
            end
            OP_MODULE_CALL_T0: begin
                b = ent(28, 2, 0, 6); c = ent(30, 2, 0, 6); wc = ent(36, 2, 2, 6);
                add = ADD_FETCH_IMM;
            end
            OP_MODULE_CALL_T1_A: begin
                b = ent(48, 5, 0, 8); c = ent(50, 5, 0, 8); wc = ent(56, 5, 2, 8);
                add = ADD_FETCH_IMM;
            end
            OP_MODULE_CALL_T1_B: begin
                b = ent(55, 6, 0, 8); c = ent(57, 6, 0, 8); wc = ent(64, 6, 2, 8);
                add = ADD_FETCH_IMM;
            end
            OP_MODULE_CALL_T1_COPY: begin
                // Base parts only; n-scaled parts added below
                b = ent(63, 0, 0, 0); c = ent(65, 0, 0, 0); wc = ent(71, 0, 2, 0);
                copy = 1'b1;
                add  = ADD_FETCH_IMM;
            end
            OP_CAS_OK: begin
                b = ent(15, 1, 0, 1); c = ent(15, 1, 0, 1); wc = ent(16, 1, 1, 1);
                add = ADD_CALC_IMM;
            end
            OP_CAS_FAIL: begin
                b = ent(12, 1, 0, 0); c = ent(12, 1, 0, 0); wc = ent(13, 1, 1, 0);
                add = ADD_CALC_IMM;
            end
            OP_DUAL_CAS_OK: begin
                b = ent(23, 2, 0, 2); c = ent(25, 2, 0, 2); wc = ent(28, 2, 2, 2);
            end
            OP_DUAL_CAS_FAIL: begin
                b = ent(19, 2, 0, 0); c = ent(22, 2, 0, 0); wc = ent(25, 2, 2, 0);
            end
            OP_BOUND_CHECK: begin
                b = ent(8, 0, 0, 0); c = ent(8, 0, 0, 0); wc = ent(8, 0, 1, 0);
                add = ADD_FETCH_EA;
            end
            OP_RANGE_CHECK: begin
                b = ent(16, 2, 0, 0); c = ent(18, 2, 0, 0); wc = ent(18, 2, 1, 0);
                add = ADD_FETCH_IMM;
            end
            OP_INDIRECT_JUMP: begin
                b = ent(1, 0, 0, 0); c = ent(4, 0, 0, 0); wc = ent(7, 0, 2, 0);
                add = ADD_JUMP_EA;
            end
            OP_SUBROUTINE_JUMP: begin
                b = ent(3, 0, 0, 1); c = ent(5, 0, 0, 1); wc = ent(11, 0, 2, 1);
                add = ADD_JUMP_EA;
            end
            OP_LOAD_EFFECTIVE_ADDRESS, OP_NOP: begin
                b = ent(2, 0, 0, 0); c = ent(2, 0, 0, 0); wc = ent(3, 0, 1, 0);
                if (req_i.op == OP_LOAD_EFFECTIVE_ADDRESS) begin
                    add = ADD_CALC_EA;
                end
            end
            OP_LINK_W: begin
                b = ent(3, 0, 0, 1); c = ent(5, 0, 0, 1); wc = ent(7, 0, 1, 1);
            end
            OP_LINK_L: begin
                b = ent(4, 0, 0, 1); c = ent(6, 0, 0, 1); wc = ent(10, 0, 2, 1);
            end
            OP_PUSH_EFFECTIVE_ADDRESS: begin
                b = ent(3, 0, 0, 1); c = ent(5, 0, 0, 1); wc = ent(6, 0, 1, 1);
                add = ADD_CALC_EA;
            end
            OP_RET_DEALLOC, OP_RET_SUB: begin
                b = ent(9, 1, 0, 0); c = ent(10, 1, 0, 0); wc = ent(12, 1, 2, 0);
            end
            OP_MODULE_RETURN_T0: begin
                b = ent(18, 4, 0, 0); c = ent(19, 4, 0, 0); wc = ent(22, 4, 2, 0);
            end
            OP_MODULE_RETURN_T1: begin
                b = ent(31, 6, 0, 1); c = ent(32, 6, 0, 1); wc = ent(35, 6, 2, 1);
            end
            OP_RET_RESTORE: begin
                b = ent(13, 2, 0, 0); c = ent(14, 2, 0, 0); wc = ent(15, 2, 2, 0);
            end
            OP_UNLINK: begin
                b = ent(5, 1, 0, 0); c = ent(6, 1, 0, 0); wc = ent(7, 1, 1, 0);
            end
            default: begin
                b = ent(0, 0, 0, 0);
            end
        endcase
        // Memory field ops need the immediate address calculation
        if ((6'(req_i.op) < 6'(FIELD_OPS)) && req_i.mem_operand) begin
            add = ADD_CALC_IMM;
        end
    end

    // =========================================================
    // Column select and next state
    ictm_ent_t   sel;
    ictm_col_t   col;
    logic [10:0] n_clk;

    always_comb begin
        // Prefetched words give best, cache hit the cache column
        if (req_i.prefetched) begin
            col = COL_BEST;
            sel = b;
        end else if (req_i.cache_hit) begin
            col = COL_CACHE;
            sel = c;
        end else begin
            col = COL_WORST;
            sel = wc;
        end
        n_clk = 11'(req_i.xfer_n) * 11'(COPY_STEP);
        next_st     = st;
        next_st.vld = req_vld_i;
        if (req_vld_i) begin
            // Totals already include all bus cycles of the triple
            next_st.rsp.total      = 11'(sel.t);
            next_st.rsp.reads      = 9'(sel.r);
            next_st.rsp.prefetches = sel.p;
            next_st.rsp.writes     = 9'(sel.w);
            next_st.rsp.add_time   = add;
            next_st.rsp.column     = col;
            if (copy) begin
                next_st.rsp.total  = 11'(sel.t) + n_clk;
                next_st.rsp.reads  = COPY_RD_BASE + 9'(req_i.xfer_n);
                next_st.rsp.writes = COPY_WR_BASE + 9'(req_i.xfer_n);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rsp_vld_o = st.vld;
    assign rsp_o     = st.rsp;
endmodule // ictm_core
`default_nettype wire

// ===== tb/ictm_assertions.sv
// Port checks for the instruction cycle timing model.
// Assumes one clock domain; bound onto every ictm_core.
`timescale 1ns/1ps
`default_nettype none
module ictm_assertions
    import ictm_pkg::*;
(
    input wire logic      clk_sys_i,  // Clock
    input wire logic      nrst_i,     // Reset, active low
    input wire logic      req_vld_i,  // Request strobe
    input wire ictm_req_t req_i,      // Request fields
    input wire logic      rsp_vld_o,  // Answer strobe
    input wire ictm_rsp_t rsp_o       // Answer
);
    // =========================================================
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    wire logic bus_fetch = !req_i.prefetched && !req_i.cache_hit;
    wire logic [7:0] n = req_i.xfer_n;
    answer_pulse_a: assert property (##1 rsp_vld_o == $past(req_vld_i))
        else $error("answer strobe wrong");
    answer_hold_a: assert property (!req_vld_i |=> $stable(rsp_o)) else $error("answer moved");
    triple_included_a: assert property (rsp_vld_o |-> rsp_o.total >= 11'(rsp_o.reads)
        + 11'(rsp_o.prefetches) + 11'(rsp_o.writes)) else $error("triple above total");
    field_span_a: assert property (req_vld_i && req_i.mem_operand &&
        req_i.op inside {[OP_FIELD_TEST:OP_FIELD_FIND_FIRST_ONE]} |=> rsp_o.reads ==
        ($past(req_i.field_5byte) ? 9'h002 : 9'h001) && rsp_o.add_time == ADD_CALC_IMM)
        else $error("field span wrong");
    branch_plain_a: assert property (req_vld_i &&
        req_i.op inside {[OP_BRANCH_TAKEN:OP_LOOP_COND_TRUE]} |=> rsp_o.add_time == ADD_NONE)
        else $error("branch add time");
    loop_taken_a: assert property (req_vld_i && req_i.op == OP_LOOP_NOT_EXPIRED |=>
        rsp_o.total == ($past(req_i.prefetched) ? 11'h003 : $past(req_i.cache_hit) ? 11'h006
        : 11'h009) && rsp_o.prefetches == ($past(bus_fetch) ? 4'h2 : 4'h0))
        else $error("loop taken timing");
    loop_expired_a: assert property (req_vld_i && req_i.op == OP_LOOP_EXPIRED |=>
        rsp_o.total == ($past(req_i.prefetched) ? 11'h007 : 11'h00A) &&
        rsp_o.prefetches == ($past(bus_fetch) ? 4'h3 : 4'h0)) else $error("loop exit timing");
    stack_copy_a: assert property (req_vld_i && req_i.op == OP_MODULE_CALL_T1_COPY &&
        req_i.prefetched |=> rsp_o.total == 11'h03F + 11'h006 * 11'($past(n)) &&
        rsp_o.reads == 9'h007 + 9'($past(n)) && rsp_o.writes == 9'h008 + 9'($past(n)))
        else $error("stack copy timing");
    jump_ea_a: assert property (req_vld_i &&
        req_i.op inside {OP_INDIRECT_JUMP, OP_SUBROUTINE_JUMP} |=> rsp_o.add_time == ADD_JUMP_EA)
        else $error("jump add time");
    imm_fetch_a: assert property (req_vld_i && req_i.op inside
        {[OP_MODULE_CALL_T0:OP_MODULE_CALL_T1_COPY], OP_RANGE_CHECK} |=>
        rsp_o.add_time == ADD_FETCH_IMM) else $error("immediate fetch add time");
    ea_calc_a: assert property (req_vld_i && req_i.op inside
        {OP_LOAD_EFFECTIVE_ADDRESS, OP_PUSH_EFFECTIVE_ADDRESS} |=> rsp_o.add_time == ADD_CALC_EA)
        else $error("address calc add time");
    column_pick_a: assert property (req_vld_i |=> rsp_o.column ==
        ($past(req_i.prefetched) ? COL_BEST : $past(req_i.cache_hit) ? COL_CACHE : COL_WORST))
        else $error("column wrong");
endmodule // ictm_assertions
bind ictm_core ictm_assertions ictm_assertions_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .req_vld_i(req_vld_i), .req_i(req_i), .rsp_vld_o(rsp_vld_o), .rsp_o(rsp_o));
`default_nettype wire

// ===== tb/ictm_mem_model.sv
// Memory side: services the bus cycles each answer announces.
// Assumes answers arrive as one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
module ictm_mem_model
    import ictm_pkg::*;
(
    input  wire logic        clk_sys_i,  // Clock
    input  wire logic        nrst_i,     // Reset, active low
    input  wire logic        rsp_vld_i,  // Answer strobe
    input  wire ictm_rsp_t   rsp_i,      // Answer
    output var  logic [31:0] cycles_o    // Bus cycles serviced
);
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cycles_o <= '0;
        end else if (rsp_vld_i) begin
            cycles_o <= cycles_o + 32'(rsp_i.reads) + 32'(rsp_i.prefetches) + 32'(rsp_i.writes);
        end
    end
endmodule // ictm_mem_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the timing model.
// Assumes requests driven on the falling edge, answers read on the next falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ictm_pkg::*;
    logic        clk_sys_i   = 1'b0;
    logic        nrst_i      = 1'b0;
    logic        req_vld_i   = 1'b0;
    ictm_req_t   req_i       = '0;
    logic        rsp_vld_o;
    ictm_rsp_t   rsp_o;
    logic [31:0] cycles;
    ictm_rsp_t   last        = '0;
    int          miscompares = 0;
    int          comparisons = 0;
    int          bus_cycles  = 0;
    ictm_core ictm_core_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_vld_i(req_vld_i),
        .req_i(req_i), .rsp_vld_o(rsp_vld_o), .rsp_o(rsp_o));
    ictm_mem_model ictm_mem_model_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .rsp_vld_i(rsp_vld_o), .rsp_i(rsp_o), .cycles_o(cycles));
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    // =========================================================
    // Helpers
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    // Column select s: 0 prefetched, 1 cache hit, 2 bus, 3 both flags
    task automatic issue(input ictm_op_t op, input logic m, f, input logic [1:0] s,
                         input logic [7:0] n, input int t, r, p, w, input ictm_add_t a);
        last = '{11'(t), 9'(r), 4'(p), 9'(w), a, (s == 2'h3) ? COL_BEST : ictm_col_t'(s)};
        req_i = '{op, m, f, s == 2'h0 || s == 2'h3, s[0], n};
        req_vld_i = 1'b1;
        @(negedge clk_sys_i);
        chk(64'(rsp_vld_o), 64'h1);
        chk(64'(rsp_o), 64'(last));
        bus_cycles += r + p + w;
    endtask
    task automatic idle();
        req_vld_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk(64'(rsp_vld_o), 64'h0);
        chk(64'(rsp_o), 64'(last));
    endtask
    task automatic finish_test();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // =========================================================
    // Scenarios
    task automatic s_reset();
        chk(64'(rsp_vld_o), 64'h0);
        chk(64'(rsp_o), 64'h0);
    endtask
    task automatic s_field();
        issue(OP_FIELD_TEST, 1'b1, 1'b1, 2'h2, 8'h00, 16, 2, 1, 0, ADD_CALC_IMM);
        issue(OP_FIELD_INSERT, 1'b1, 1'b0, 2'h0, 8'h00, 14, 1, 0, 1, ADD_CALC_IMM);
        issue(OP_FIELD_INVERT, 1'b0, 1'b1, 2'h1, 8'h00, 12, 0, 0, 0, ADD_NONE);
        issue(OP_FIELD_EXTRACT_SIGNED, 1'b1, 1'b1, 2'h1, 8'h00, 18, 2, 0, 0,
              ADD_CALC_IMM);
        issue(OP_FIELD_FIND_FIRST_ONE, 1'b1, 1'b1, 2'h3, 8'h00, 32, 2, 0, 0, ADD_CALC_IMM);
        idle();
    endtask
    // Back to back: every answer must follow its own request
    task automatic s_loop();
        issue(OP_LOOP_NOT_EXPIRED, 1'b0, 1'b0, 2'h0, 8'h00, 3, 0, 0, 0, ADD_NONE);
        issue(OP_LOOP_NOT_EXPIRED, 1'b0, 1'b0, 2'h1, 8'h00, 6, 0, 0, 0, ADD_NONE);
        issue(OP_LOOP_NOT_EXPIRED, 1'b0, 1'b0, 2'h2, 8'h00, 9, 0, 2, 0, ADD_NONE);
        issue(OP_LOOP_EXPIRED, 1'b0, 1'b0, 2'h0, 8'h00, 7, 0, 0, 0, ADD_NONE);
        issue(OP_LOOP_EXPIRED, 1'b0, 1'b0, 2'h1, 8'h00, 10, 0, 0, 0, ADD_NONE);
        issue(OP_LOOP_EXPIRED, 1'b0, 1'b0, 2'h2, 8'h00, 10, 0, 3, 0, ADD_NONE);
        issue(OP_LOOP_COND_TRUE, 1'b0, 1'b0, 2'h2, 8'h00, 7, 0, 1, 0, ADD_NONE);
        issue(OP_BRANCH_NT_L, 1'b0, 1'b0, 2'h2, 8'h00, 9, 0, 2, 0, ADD_NONE);
        idle();
    endtask
    task automatic s_call();
        issue(OP_MODULE_CALL_T1_COPY, 1'b0, 1'b0, 2'h0, 8'h00, 63, 7, 0, 8,
              ADD_FETCH_IMM);
        issue(OP_MODULE_CALL_T1_COPY, 1'b0, 1'b0, 2'h2, 8'hFF, 1601, 262, 2, 263,
              ADD_FETCH_IMM);
        issue(OP_MODULE_CALL_T1_COPY, 1'b0, 1'b0, 2'h1, 8'h03, 83, 10, 0, 11,
              ADD_FETCH_IMM);
        issue(OP_MODULE_CALL_T0, 1'b0, 1'b0, 2'h2, 8'h00, 36, 2, 2, 6, ADD_FETCH_IMM);
        issue(OP_RANGE_CHECK, 1'b0, 1'b0, 2'h0, 8'h00, 16, 2, 0, 0, ADD_FETCH_IMM);
        issue(OP_CAS_OK, 1'b0, 1'b0, 2'h0, 8'h00, 15, 1, 0, 1, ADD_CALC_IMM);
        idle();
    endtask
    task automatic s_jump();
        issue(OP_INDIRECT_JUMP, 1'b0, 1'b0, 2'h2, 8'h00, 7, 0, 2, 0, ADD_JUMP_EA);
        issue(OP_SUBROUTINE_JUMP, 1'b0, 1'b0, 2'h0, 8'h00, 3, 0, 0, 1, ADD_JUMP_EA);
        issue(OP_LOAD_EFFECTIVE_ADDRESS, 1'b0, 1'b0, 2'h1, 8'h00, 2, 0, 0, 0, ADD_CALC_EA);
        issue(OP_PUSH_EFFECTIVE_ADDRESS, 1'b0, 1'b0, 2'h2, 8'h00, 6, 0, 1, 1, ADD_CALC_EA);
        issue(OP_BOUND_CHECK, 1'b0, 1'b0, 2'h0, 8'h00, 8, 0, 0, 0, ADD_FETCH_EA);
        idle();
        chk(64'(cycles), 64'(bus_cycles));
    endtask
    initial begin
        repeat (8) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        s_reset();
        s_field();
        s_loop();
        s_call();
        s_jump();
        finish_test();
    end
    // Whole run is under a hundred cycles; allow ten times that
    initial begin
        #25000;
        miscompares++;
        finish_test();
    end
endmodule // tb
`default_nettype wire
